// [design/tlic_map.vh]
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH

// Special-function register addresses.
`define TLIC_SFR_IE 8'ha8
`define TLIC_SFR_IRQ_ENABLE_PRIORITY_SECONDARY 8'ha9
`define TLIC_SFR_IP 8'hb8

// Reset values of the three registers.
`define TLIC_IE_RST 8'h00
`define TLIC_IRQ_ENABLE_PRIORITY_SECONDARY_RST 8'ha0
`define TLIC_IP_RST 8'h00

// Main enable and main priority field positions (shared layout).
`define TLIC_BIT_GLOBAL 7
`define TLIC_BIT_ADC 6
`define TLIC_BIT_T2 5
`define TLIC_BIT_UART 4
`define TLIC_BIT_T1 3
`define TLIC_BIT_EXT1 2
`define TLIC_BIT_T0 1
`define TLIC_BIT_EXT0 0

// Main priority register: the top bit is reserved and reads as zero.
`define TLIC_IP_MASK 8'h7f

// Secondary enable and priority field positions.
`define TLIC_BIT_TIC_PRIO 6
`define TLIC_BIT_PSM_PRIO 5
`define TLIC_BIT_SPI_PRIO 4
`define TLIC_BIT_TIC_EN 2
`define TLIC_BIT_PSM_EN 1
`define TLIC_BIT_SPI_EN 0

// Source index, in polling order within one level (0 is polled first).
`define TLIC_NUM_SRC 11
`define TLIC_SRC_PSM 4'd0
`define TLIC_SRC_WDOG 4'd1
`define TLIC_SRC_EXT0 4'd2
`define TLIC_SRC_ADC 4'd3
`define TLIC_SRC_T0 4'd4
`define TLIC_SRC_EXT1 4'd5
`define TLIC_SRC_T1 4'd6
`define TLIC_SRC_SPI 4'd7
`define TLIC_SRC_UART 4'd8
`define TLIC_SRC_T2 4'd9
`define TLIC_SRC_TIC 4'd10

// Fixed vector addresses.
`define TLIC_VEC_EXT0 16'h0003
`define TLIC_VEC_T0 16'h000b
`define TLIC_VEC_EXT1 16'h0013
`define TLIC_VEC_T1 16'h001b
`define TLIC_VEC_UART 16'h0023
`define TLIC_VEC_T2 16'h002b
`define TLIC_VEC_ADC 16'h0033
`define TLIC_VEC_SPI 16'h003b
`define TLIC_VEC_PSM 16'h0043
`define TLIC_VEC_TIC 16'h0053
`define TLIC_VEC_WDOG 16'h005b

`endif

// [design/tlic_top.v]
`include "tlic_map.vh"
`default_nettype none

module tlic_top (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Special-function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output reg sfr_hit,
    // Request flags from the peripherals
    input wire supply_monitor_flag,
    input wire watchdog_irq_flag,
    input wire ext_input0_flag,
    input wire adc_irq_flag,
    input wire timer0_overflow_flag,
    input wire ext_input1_flag,
    input wire timer1_overflow_flag,
    input wire serial_port_flag,
    input wire uart_rx_flag,
    input wire uart_tx_flag,
    input wire timer2_overflow_flag,
    input wire timer2_external_flag,
    input wire tic_irq_flag,
    // Processor core side
    input wire core_boundary,
    input wire [15:0] core_pc,
    input wire core_reti,
    output wire irq_pending,
    output reg stack_push,
    output reg [15:0] stack_data,
    output reg pc_load,
    output reg [15:0] pc_load_value,
    output reg [10:0] irq_ack_src,
    output reg service_high,
    output reg service_low
);

    // Sequencer states.
    localparam ST_IDLE = 1'b0;
    localparam ST_LOAD = 1'b1;

    // Registers.
    reg [7:0] irq_enable_reg;
    reg [7:0] irq_enable_next;
    reg [7:0] secondary_enable_priority_reg;
    reg [7:0] secondary_enable_priority_next;
    reg [7:0] irq_priority_reg;
    reg [7:0] irq_priority_next;
    reg state_reg;
    reg state_next;
    reg [3:0] src_reg;

    // Named fields of the registers.
    wire global_irq_enable;
    wire adc_irq_enable;
    wire timer2_irq_enable;
    wire uart_irq_enable;
    wire timer1_irq_enable;
    wire ext1_irq_enable;
    wire timer0_irq_enable;
    wire ext0_irq_enable;
    wire adc_prio;
    wire timer2_prio;
    wire uart_prio;
    wire timer1_prio;
    wire ext1_prio;
    wire timer0_prio;
    wire ext0_prio;
    wire tic_irq_prio;
    wire supply_monitor_prio;
    wire spi_i2c_prio;
    wire tic_irq_enable;
    wire supply_monitor_irq_enable;
    wire spi_i2c_irq_enable;

    // Per-source vectors, indexed in polling order.
    wire [10:0] src_request;
    wire [10:0] src_enable;
    wire [10:0] src_high;
    wire [10:0] cand_high;
    wire [10:0] cand_low;
    wire [4:0] pick_high;
    wire [4:0] pick_low;
    wire take_high;
    wire take_low;
    wire [3:0] pick_idx;
    wire accept;

    // Returns {found, index} of the first set bit in polling order.
    function [4:0] poll_pick;
        input [10:0] cand;
        integer i;
        begin
            poll_pick = 5'h00;
            for (i = `TLIC_NUM_SRC - 1; i >= 0; i = i - 1) begin
                if (cand[i]) begin
                    poll_pick = {1'b1, i[3:0]};
                end
            end
        end
    endfunction

    // Maps a source index to its fixed vector address.
    function [15:0] vector_of;
        input [3:0] idx;
        begin
            case (idx)
                `TLIC_SRC_PSM: vector_of = `TLIC_VEC_PSM;
                `TLIC_SRC_WDOG: vector_of = `TLIC_VEC_WDOG;
                `TLIC_SRC_EXT0: vector_of = `TLIC_VEC_EXT0;
                `TLIC_SRC_ADC: vector_of = `TLIC_VEC_ADC;
                `TLIC_SRC_T0: vector_of = `TLIC_VEC_T0;
                `TLIC_SRC_EXT1: vector_of = `TLIC_VEC_EXT1;
                `TLIC_SRC_T1: vector_of = `TLIC_VEC_T1;
                `TLIC_SRC_SPI: vector_of = `TLIC_VEC_SPI;
                `TLIC_SRC_UART: vector_of = `TLIC_VEC_UART;
                `TLIC_SRC_T2: vector_of = `TLIC_VEC_T2;
                `TLIC_SRC_TIC: vector_of = `TLIC_VEC_TIC;
                default: vector_of = `TLIC_VEC_EXT0;
            endcase
        end
    endfunction

    // Field extraction from the main enable register.
    assign global_irq_enable = irq_enable_reg[`TLIC_BIT_GLOBAL];
    assign adc_irq_enable = irq_enable_reg[`TLIC_BIT_ADC];
    assign timer2_irq_enable = irq_enable_reg[`TLIC_BIT_T2];
    assign uart_irq_enable = irq_enable_reg[`TLIC_BIT_UART];
    assign timer1_irq_enable = irq_enable_reg[`TLIC_BIT_T1];
    assign ext1_irq_enable = irq_enable_reg[`TLIC_BIT_EXT1];
    assign timer0_irq_enable = irq_enable_reg[`TLIC_BIT_T0];
    assign ext0_irq_enable = irq_enable_reg[`TLIC_BIT_EXT0];

    // Field extraction from the main priority register.
    assign adc_prio = irq_priority_reg[`TLIC_BIT_ADC];
    assign timer2_prio = irq_priority_reg[`TLIC_BIT_T2];
    assign uart_prio = irq_priority_reg[`TLIC_BIT_UART];
    assign timer1_prio = irq_priority_reg[`TLIC_BIT_T1];
    assign ext1_prio = irq_priority_reg[`TLIC_BIT_EXT1];
    assign timer0_prio = irq_priority_reg[`TLIC_BIT_T0];
    assign ext0_prio = irq_priority_reg[`TLIC_BIT_EXT0];

    // Field extraction from the secondary register.
    assign tic_irq_prio = secondary_enable_priority_reg[`TLIC_BIT_TIC_PRIO];
    assign supply_monitor_prio = secondary_enable_priority_reg[`TLIC_BIT_PSM_PRIO];
    assign spi_i2c_prio = secondary_enable_priority_reg[`TLIC_BIT_SPI_PRIO];
    assign tic_irq_enable = secondary_enable_priority_reg[`TLIC_BIT_TIC_EN];
    assign supply_monitor_irq_enable = secondary_enable_priority_reg[`TLIC_BIT_PSM_EN];
    assign spi_i2c_irq_enable = secondary_enable_priority_reg[`TLIC_BIT_SPI_EN];

    // Requests gathered in polling order; watchdog ranks before external input zero.
    assign src_request = {tic_irq_flag,
                          timer2_overflow_flag | timer2_external_flag,
                          uart_rx_flag | uart_tx_flag,
                          serial_port_flag,
                          timer1_overflow_flag,
                          ext_input1_flag,
                          timer0_overflow_flag,
                          adc_irq_flag,
                          ext_input0_flag,
                          watchdog_irq_flag,
                          supply_monitor_flag};

    // Individual enables; the watchdog has no enable bit and is always on.
    assign src_enable = {tic_irq_enable, timer2_irq_enable, uart_irq_enable,
                         spi_i2c_irq_enable, timer1_irq_enable, ext1_irq_enable,
                         timer0_irq_enable, adc_irq_enable, ext0_irq_enable,
                         1'b1, supply_monitor_irq_enable};

    // Level selection; the watchdog always sits at the high level.
    assign src_high = {tic_irq_prio, timer2_prio, uart_prio, spi_i2c_prio,
                       timer1_prio, ext1_prio, timer0_prio, adc_prio, ext0_prio,
                       1'b1, supply_monitor_prio};

    // Candidates per level; a running high routine blocks everything,
    // a running low routine blocks only low requests.
    assign cand_high = (global_irq_enable && !service_high) ?
                       (src_request & src_enable & src_high) : 11'h000;
    assign cand_low = (global_irq_enable && !service_high && !service_low) ?
                      (src_request & src_enable & ~src_high) : 11'h000;

    // Polling within each level, then high level over low level.
    assign pick_high = poll_pick(cand_high);
    assign pick_low = poll_pick(cand_low);
    assign take_high = pick_high[4];
    assign take_low = !take_high && pick_low[4];
    assign pick_idx = take_high ? pick_high[3:0] : pick_low[3:0];

    // Request to the core and acceptance at an instruction boundary.
    assign irq_pending = (state_reg == ST_IDLE) && (take_high || take_low);
    assign accept = irq_pending && core_boundary;

    // Register write decode; unmapped addresses leave all registers alone.
    always @* begin
        irq_enable_next = irq_enable_reg;
        secondary_enable_priority_next = secondary_enable_priority_reg;
        irq_priority_next = irq_priority_reg;
        if (sfr_wr) begin
            case (sfr_addr)
                `TLIC_SFR_IE: irq_enable_next = sfr_wdata;
                `TLIC_SFR_IRQ_ENABLE_PRIORITY_SECONDARY: secondary_enable_priority_next = sfr_wdata;
                `TLIC_SFR_IP: irq_priority_next = sfr_wdata & `TLIC_IP_MASK;
                default: irq_enable_next = irq_enable_reg;
            endcase
        end
    end

    // Register storage.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            irq_enable_reg <= `TLIC_IE_RST;
            secondary_enable_priority_reg <= `TLIC_IRQ_ENABLE_PRIORITY_SECONDARY_RST;
            irq_priority_reg <= `TLIC_IP_RST;
        end else begin
            irq_enable_reg <= irq_enable_next;
            secondary_enable_priority_reg <= secondary_enable_priority_next;
            irq_priority_reg <= irq_priority_next;
        end
    end

    // Read data is registered one cycle after the read strobe.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            sfr_hit <= 1'b0;
        end else if (sfr_rd) begin
            case (sfr_addr)
                `TLIC_SFR_IE: begin
                    sfr_rdata <= irq_enable_reg;
                    sfr_hit <= 1'b1;
                end
                `TLIC_SFR_IRQ_ENABLE_PRIORITY_SECONDARY: begin
                    sfr_rdata <= secondary_enable_priority_reg;
                    sfr_hit <= 1'b1;
                end
                `TLIC_SFR_IP: begin
                    sfr_rdata <= irq_priority_reg;
                    sfr_hit <= 1'b1;
                end
                default: begin
                    sfr_rdata <= 8'h00;
                    sfr_hit <= 1'b0;
                end
            endcase
        end
    end

    // Two-step sequencer: push the return address, then load the vector.
    always @* begin
        case (state_reg)
            ST_IDLE: state_next = accept ? ST_LOAD : ST_IDLE;
            ST_LOAD: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Core-facing outputs; the vector follows the push by one cycle.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            src_reg <= 4'h0;
            stack_push <= 1'b0;
            stack_data <= 16'h0000;
            pc_load <= 1'b0;
            pc_load_value <= 16'h0000;
            irq_ack_src <= 11'h000;
        end else begin
            state_reg <= state_next;
            stack_push <= accept;
            pc_load <= (state_reg == ST_LOAD);
            irq_ack_src <= 11'h000;
            if (accept) begin
                src_reg <= pick_idx;
                stack_data <= core_pc;
                irq_ack_src <= 11'h001 << pick_idx;
            end
            if (state_reg == ST_LOAD) begin
                pc_load_value <= vector_of(src_reg);
            end
        end
    end

    // In-service levels: a return ends the highest level in service; an
    // acceptance in the same cycle is applied after it, so the set wins.
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            service_high <= 1'b0;
            service_low <= 1'b0;
        end else begin
            if (core_reti) begin
                if (service_high) begin
                    service_high <= 1'b0;
                end else begin
                    service_low <= 1'b0;
                end
            end
            if (accept && take_high) begin
                service_high <= 1'b1;
            end
            if (accept && take_low) begin
                service_low <= 1'b1;
            end
        end
    end

endmodule // tlic_top

`default_nettype wire

// [dv/tlic_top_props.sv]
`default_nettype none
module tlic_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Core side
    input wire logic core_boundary,
    input wire logic [15:0] core_pc,
    input wire logic core_reti,
    input wire logic irq_pending,
    input wire logic stack_push,
    input wire logic [15:0] stack_data,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic [10:0] irq_ack_src,
    input wire logic service_high,
    input wire logic service_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic glob_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Shadow of the global enable bit, followed from register writes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) glob_reg <= 1'b0;
        else if (sfr_wr && sfr_addr == 8'ha8) glob_reg <= sfr_wdata[7];
    end
    // Entry sequence, vectors, nesting and register reads.
    chk_global_gate: assert property (!glob_reg |-> !irq_pending)
        else $error("request offered while globally disabled");
    chk_push_saves_pc: assert property (irq_pending && core_boundary |=>
        stack_push && stack_data == $past(core_pc)) else $error("bad push");
    chk_push_then_load: assert property (stack_push |=> pc_load && !stack_push)
        else $error("vector load does not follow push");
    chk_ext0_vector: assert property (irq_ack_src == 11'h004 |=>
        pc_load_value == 16'h0003) else $error("wrong ext0 vector");
    chk_wdog_vector: assert property (irq_ack_src == 11'h002 |=>
        pc_load_value == 16'h005b) else $error("wrong watchdog vector");
    chk_same_level: assert property (service_high && !core_reti |=> !stack_push)
        else $error("high routine was interrupted");
    chk_low_preempt: assert property (stack_push && $past(service_low) &&
        !$past(core_reti) |-> service_high) else $error("low routine nested low");
    chk_ret_clears: assert property (core_reti && service_high |=> !service_high)
        else $error("return left high level in service");
    chk_ret_low_clears: assert property (core_reti && !service_high && service_low |=>
        !service_low) else $error("return left low level in service");
    chk_unmapped_read: assert property (sfr_rd && !(sfr_addr inside {8'ha8, 8'ha9,
        8'hb8}) |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read hit");
    chk_prio_top_bit: assert property (sfr_rd && sfr_addr == 8'hb8 |=>
        sfr_hit && !sfr_rdata[7]) else $error("priority bit 7 not zero");
endmodule // tlic_props
bind tlic_top tlic_props u_props (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .core_boundary(core_boundary),
    .core_pc(core_pc),
    .core_reti(core_reti),
    .irq_pending(irq_pending),
    .stack_push(stack_push),
    .stack_data(stack_data),
    .pc_load(pc_load),
    .pc_load_value(pc_load_value),
    .irq_ack_src(irq_ack_src),
    .service_high(service_high),
    .service_low(service_low)
);
`default_nettype wire

// [dv/tlic_core_model.sv]
`default_nettype none
module tlic_core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench controls
    input wire logic slow,
    input wire logic ret_req,
    // Controller side
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    output logic core_boundary,
    output logic [15:0] core_pc,
    output logic core_reti
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] depth_reg;
    logic phase_reg;
    // In slow mode a boundary is only offered every other cycle.
    assign core_boundary = !slow || phase_reg;
    // The counter runs on and jumps to each vector; returns need an open routine.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            core_pc <= 16'h0100;
            depth_reg <= 4'h0;
            phase_reg <= 1'b0;
            core_reti <= 1'b0;
        end else begin
            phase_reg <= !phase_reg;
            core_pc <= pc_load ? pc_load_value : core_pc + 16'h0001;
            core_reti <= ret_req && depth_reg != 4'h0;
            depth_reg <= depth_reg + {3'h0, pc_load} - {3'h0, core_reti};
        end
    end
endmodule // tlic_core_model
`default_nettype wire

// [dv/test_tlic_top.sv]
`default_nettype none
module test_tlic_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rst_n, sfr_wr, sfr_rd, slow, ret_req, core_reti, core_boundary;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [12:0] fl;
    logic [15:0] core_pc;
    wire sfr_hit, irq_pending, stack_push, pc_load, service_high, service_low;
    wire [15:0] stack_data, pc_load_value;
    wire [10:0] irq_ack_src;
    int n_errors = 0;
    int checked = 0;
    logic [15:0] vs[11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
        16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
    int st[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 8, 9, 9, 10};
    // Controller and core model.
    tlic_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .supply_monitor_flag(fl[0]), .watchdog_irq_flag(fl[1]),
        .ext_input0_flag(fl[2]), .adc_irq_flag(fl[3]), .timer0_overflow_flag(fl[4]),
        .ext_input1_flag(fl[5]), .timer1_overflow_flag(fl[6]), .serial_port_flag(fl[7]),
        .uart_rx_flag(fl[8]), .uart_tx_flag(fl[9]), .timer2_overflow_flag(fl[10]),
        .timer2_external_flag(fl[11]), .tic_irq_flag(fl[12]),
        .core_boundary(core_boundary), .core_pc(core_pc), .core_reti(core_reti),
        .irq_pending(irq_pending), .stack_push(stack_push), .stack_data(stack_data),
        .pc_load(pc_load), .pc_load_value(pc_load_value), .irq_ack_src(irq_ack_src),
        .service_high(service_high), .service_low(service_low));
    tlic_core_model u_core (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
        .ret_req(ret_req), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .core_boundary(core_boundary), .core_pc(core_pc), .core_reti(core_reti));
    // Compare and count.
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] d, logic hit);
        @(negedge clk_sys);
        {sfr_addr, sfr_rd} = {a, 1'b1};
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        check("sfr read", {7'h00, sfr_hit, sfr_rdata}, {7'h00, hit, d});
    endtask
    // Waits for one entry and judges its vector and source.
    task automatic svc(int s);
        logic [10:0] ack = 11'h000;
        int n = 0;
        // At least one edge passes, so a load left over from the previous entry is not
        // taken for this one; a push that already stands on entry is still caught.
        do begin
            if (stack_push === 1'b1) ack = irq_ack_src;
            @(negedge clk_sys);
            n++;
        end while (pc_load !== 1'b1 && n < 40);
        check("load", {15'h0, pc_load}, 16'h0001);
        check("vector", pc_load_value, vs[s]);
        check("ack", {5'h00, ack}, {5'h00, 11'h001 << s});
    endtask
    task automatic none(int n);
        repeat (n) @(negedge clk_sys) check("quiet", {15'h0, stack_push}, 16'h0000);
    endtask
    task automatic ret();
        @(negedge clk_sys) ret_req = 1'b1;
        @(negedge clk_sys) ret_req = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic t_regs();
        rd(8'ha8, 8'h00, 1'b1);
        rd(8'ha9, 8'ha0, 1'b1);
        rd(8'hb8, 8'h00, 1'b1);
        rd(8'h5a, 8'h00, 1'b0);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h7f, 1'b1);
        wr(8'ha9, 8'h77);
        rd(8'ha9, 8'h77, 1'b1);
    endtask
    task automatic t_gate();
        wr(8'hb8, 8'h00);
        wr(8'ha8, 8'h01);
        fl = 13'h0004;
        none(8);
        wr(8'ha8, 8'h80);
        none(8);
        wr(8'ha8, 8'h81);
        svc(2);
        fl = 13'h0000;
        ret();
    endtask
    // Every request input alone, with fast and slow boundaries.
    task automatic t_vec();
        wr(8'ha8, 8'hff);
        wr(8'ha9, 8'h07);
        for (int i = 0; i < 13; i++) begin
            slow = i[0];
            fl = 13'h0001 << i;
            svc(st[i]);
            fl = 13'h0000;
            ret();
        end
        slow = 1'b0;
    endtask
    task automatic t_poll();
        fl = 13'h1ffd;
        for (int s = 0; s < 11; s++) begin
            if (s != 1) begin
                svc(s);
                for (int j = 0; j < 13; j++) if (st[j] == s) fl[j] = 1'b0;
                ret();
            end
        end
    endtask
    task automatic t_nest();
        wr(8'hb8, 8'h0a);
        fl = 13'h0004;
        svc(2);
        fl[4] = 1'b1;
        svc(4);
        fl[6] = 1'b1;
        none(6);
        fl[4] = 1'b0;
        ret();
        svc(6);
        fl = 13'h0000;
        ret();
        ret();
        fl = 13'h0044;
        svc(6);
        fl = 13'h0000;
        ret();
        wr(8'hb8, 8'h01);
        fl = 13'h0006;
        svc(1);
        fl = 13'h0004;
        ret();
        svc(2);
        fl = 13'h0000;
        ret();
    endtask
    task automatic complete_run();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Watchdog on the whole run.
    initial begin
        #200000;
        n_errors++;
        complete_run();
    end
    // Main sequence.
    initial begin
        {rst_n, sfr_wr, sfr_rd, slow, ret_req, sfr_addr, sfr_wdata, fl} = '0;
        repeat (16) @(negedge clk_sys);
        rst_n = 1'b1;
        t_regs();
        t_gate();
        t_vec();
        t_poll();
        t_nest();
        complete_run();
    end
endmodule // test_tlic_top
`default_nettype wire
